// ---- core/sfl_guard.sv ----
// self-programming flash access guard with APB control registers
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "sfl_consts.svh"
module sfl_guard #(
	parameter int            AW          = 15,
	parameter logic [AW-1:0] HALT_BASE   = 15'h7000,
	parameter logic [AW-1:0] LOADER_BASE = 15'h7800,
	parameter int            PROG_CYCLES = `SFL_PROG_CYCLES
) (
	input  wire logic          CORE_CLK,
	input  wire logic          SYS_RST,
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [11:0]   PADDR,
	input  wire logic [31:0]   PWDATA,
	output logic      [31:0]   PRDATA,
	output logic               PREADY,
	output logic               PSLVERR,
	input  wire logic          SPM_REQ,
	input  wire logic [1:0]    SPM_KIND,
	input  wire logic [AW-1:0] SPM_ADDR,
	input  wire logic [3:0]    SPM_LOCK_DATA,
	input  wire logic          LPM_REQ,
	input  wire logic [AW-1:0] LPM_ADDR,
	input  wire logic [AW-1:0] PC_ADDR,
	input  wire logic          IRQ_IN,
	input  wire logic          EXT_LOCK_WE,
	input  wire logic [3:0]    EXT_LOCK_DATA,
	input  wire logic          EXT_CHIP_ERASE,
	output logic               CPU_STALL,
	output logic               CONC_READ_BLOCK,
	output logic               LPM_GRANT,
	output logic               LPM_DENY,
	output logic               IRQ_OUT,
	output logic               FLASH_ERASE_GO,
	output logic               FLASH_WRITE_GO,
	output logic      [AW-1:0] FLASH_PAGE,
	output logic               SPM_REJECT
);
	sfl_core_if c ();

	logic [3:0]  lock_r;
	logic        ivec_r;
	logic        busy_r;
	logic        rej_r;
	logic [31:0] prdata_r;
	logic        erase_go_r;
	logic        write_go_r;
	logic [AW-1:0] page_r;
	logic        spm_rej_r;
	logic        irq_r;
	logic [5:0]  ext_s1_r;
	logic [5:0]  ext_s2_r;
	logic        ext_we_d_r;
	logic        ext_ce_d_r;
	logic        ext_we_p;
	logic        ext_ce_p;
	logic        apb_wr;
	logic        apb_setup;
	logic        addr_hit;
	logic        spm_prog;
	logic        spm_go;
	logic        spm_rej;
	logic        go_halt;
	logic        lockset;
	logic        busy_clr;
	logic        rej_clr;
	logic        lpm_ok;
	logic [31:0] rd_mux;

	sfl_lock_policy u_pol (
		.p (c.pol)
	);

	sfl_prog_seq #(
		.CYCLES (PROG_CYCLES)
	) u_seq (
		.clk (CORE_CLK),
		.rst (SYS_RST),
		.s   (c.seq)
	);

	// region decode: loader lies wholly inside the halting region
	assign c.app_lock    = lock_r[`SFL_LOCK_APP_LSB +: 2];
	assign c.ldr_lock    = lock_r[`SFL_LOCK_LDR_LSB +: 2];
	assign c.pc_in_ldr   = (PC_ADDR >= LOADER_BASE);
	assign c.ivec_in_ldr = ivec_r;
	assign c.spm_tgt_ldr = (SPM_ADDR >= LOADER_BASE);
	assign c.lpm_tgt_ldr = (LPM_ADDR >= LOADER_BASE);

	// store requests; ignored while an operation runs
	assign spm_prog = SPM_REQ && c.pc_in_ldr && !c.active &&
		(SPM_KIND == sfl_pkg::SFL_SPM_ERASE || SPM_KIND == sfl_pkg::SFL_SPM_WRITE);
	assign spm_go   = spm_prog && c.spm_write_ok;
	assign spm_rej  = spm_prog && !c.spm_write_ok;
	assign go_halt  = (SPM_ADDR >= HALT_BASE);
	assign lockset  = SPM_REQ && c.pc_in_ldr && !c.active && SPM_KIND == sfl_pkg::SFL_SPM_LOCKSET;
	assign c.start      = spm_go;
	assign c.start_halt = go_halt;

	// external programming pins cross into the core clock here
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ext_s1_r   <= 6'h00;
			ext_s2_r   <= 6'h00;
			ext_we_d_r <= 1'b0;
			ext_ce_d_r <= 1'b0;
		end else begin
			ext_s1_r   <= {EXT_CHIP_ERASE, EXT_LOCK_WE, EXT_LOCK_DATA};
			ext_s2_r   <= ext_s1_r;
			ext_we_d_r <= ext_s2_r[4];
			ext_ce_d_r <= ext_s2_r[5];
		end
	end
	assign ext_we_p = ext_s2_r[4] && !ext_we_d_r;
	assign ext_ce_p = ext_s2_r[5] && !ext_ce_d_r;

	// lock bits can only move toward programmed (0) except on chip erase or system reset
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			lock_r <= `SFL_LOCK_RESET;
		end else if (ext_ce_p) begin
			lock_r <= `SFL_LOCK_RESET;
		end else if (ext_we_p) begin
			lock_r <= lock_r & ext_s2_r[3:0];
		end else if (lockset) begin
			lock_r <= lock_r & SPM_LOCK_DATA;
		end
	end

	// APB slave, zero wait states
	assign apb_setup = PSEL && !PENABLE;
	assign apb_wr    = PSEL && PENABLE && PWRITE;
	assign addr_hit  = (PADDR == `SFL_OFS_CTRL) || (PADDR == `SFL_OFS_LOCK) || (PADDR == `SFL_OFS_STAT);
	assign PREADY    = 1'b1;
	assign PSLVERR   = PSEL && PENABLE && !addr_hit;
	assign busy_clr  = apb_wr && PADDR == `SFL_OFS_CTRL && PWDATA[`SFL_CTRL_BCLR_BIT];
	assign rej_clr   = apb_wr && PADDR == `SFL_OFS_CTRL && PWDATA[`SFL_CTRL_RCLR_BIT];

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (PADDR)
			`SFL_OFS_CTRL: rd_mux[`SFL_CTRL_IVEC_BIT] = ivec_r;
			`SFL_OFS_LOCK: rd_mux[3:0] = lock_r;
			`SFL_OFS_STAT: begin
				rd_mux[`SFL_STAT_BUSY_BIT] = busy_r;
				rd_mux[`SFL_STAT_HALT_BIT] = c.halting;
				rd_mux[`SFL_STAT_ACT_BIT]  = c.active;
				rd_mux[`SFL_STAT_REJ_BIT]  = rej_r;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			prdata_r <= 32'h0000_0000;
		end else if (apb_setup && !PWRITE) begin
			prdata_r <= rd_mux;
		end
	end
	assign PRDATA = prdata_r;

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ivec_r <= 1'b0;
		end else if (apb_wr && PADDR == `SFL_OFS_CTRL) begin
			ivec_r <= PWDATA[`SFL_CTRL_IVEC_BIT];
		end
	end

	// busy flag: set on a concurrent-region start, software clear only after finish
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			busy_r <= 1'b0;
		end else if (spm_go && !go_halt) begin
			busy_r <= 1'b1;
		end else if (busy_clr && !c.active) begin
			busy_r <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rej_r <= 1'b0;
		end else if (spm_rej) begin
			rej_r <= 1'b1;
		end else if (rej_clr) begin
			rej_r <= 1'b0;
		end
	end

	// flash command strobes toward the array
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			erase_go_r <= 1'b0;
			write_go_r <= 1'b0;
			page_r     <= '0;
			spm_rej_r  <= 1'b0;
		end else begin
			erase_go_r <= spm_go && SPM_KIND == sfl_pkg::SFL_SPM_ERASE;
			write_go_r <= spm_go && SPM_KIND == sfl_pkg::SFL_SPM_WRITE;
			spm_rej_r  <= spm_rej;
			if (spm_go) begin
				page_r <= SPM_ADDR;
			end
		end
	end
	assign FLASH_ERASE_GO = erase_go_r;
	assign FLASH_WRITE_GO = write_go_r;
	assign FLASH_PAGE     = page_r;
	assign SPM_REJECT     = spm_rej_r;
	assign CPU_STALL      = c.halting;
	assign CONC_READ_BLOCK = busy_r;

	// loads: lock policy plus concurrent region blocked while busy
	assign lpm_ok    = c.lpm_read_ok && !(busy_r && LPM_ADDR < HALT_BASE);
	assign LPM_GRANT = LPM_REQ && lpm_ok;
	assign LPM_DENY  = LPM_REQ && !lpm_ok;

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= IRQ_IN && !c.irq_suppress;
		end
	end
	assign IRQ_OUT = irq_r;

	stall_halt_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		spm_go && go_halt |=> CPU_STALL [*8])
		else $error("halting-region operation did not stall");

	conc_run_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		spm_go && !go_halt |=> !CPU_STALL && CONC_READ_BLOCK)
		else $error("concurrent-region operation stalled or left region readable");

	busy_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		c.active && !c.halting |-> ##1 CONC_READ_BLOCK)
		else $error("busy flag dropped during concurrent operation");

	lock_prog_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		!ext_ce_p |=> (lock_r & ~$past(lock_r)) == 4'h0)
		else $error("lock bit returned to unprogrammed without chip erase");

	app_nostore_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		SPM_REQ && !c.pc_in_ldr |=> !FLASH_ERASE_GO && !FLASH_WRITE_GO)
		else $error("store from application region started programming");

	rej_quiet_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		spm_rej |=> SPM_REJECT && !FLASH_WRITE_GO && !FLASH_ERASE_GO && !CPU_STALL)
		else $error("rejected store touched flash or stalled");

	app_wrlock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		spm_prog && !c.spm_tgt_ldr && !lock_r[`SFL_LOCK_APP_LSB] |=> SPM_REJECT)
		else $error("store into write-locked application region accepted");

	ldr_rdlock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		LPM_REQ && !c.pc_in_ldr && c.lpm_tgt_ldr && !lock_r[`SFL_LOCK_LDR_LSB + 1] |-> LPM_DENY)
		else $error("application read of read-locked loader region granted");

	irq_mask_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		IRQ_IN && !c.pc_in_ldr && ivec_r && !lock_r[`SFL_LOCK_APP_LSB + 1] |=> !IRQ_OUT)
		else $error("interrupt passed while application lock masks it");

	ldr_wrlock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		spm_prog && c.spm_tgt_ldr && !lock_r[`SFL_LOCK_LDR_LSB] |=> SPM_REJECT)
		else $error("store into write-locked loader region accepted");

	app_rdlock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		LPM_REQ && c.pc_in_ldr && !c.lpm_tgt_ldr && !lock_r[`SFL_LOCK_APP_LSB + 1] |-> LPM_DENY)
		else $error("loader read of read-locked application region granted");

	ldr_irqmask_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		IRQ_IN && c.pc_in_ldr && !ivec_r && !lock_r[`SFL_LOCK_LDR_LSB + 1] |=> !IRQ_OUT)
		else $error("interrupt passed while loader lock masks it");

	busy_read_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		LPM_REQ && busy_r && LPM_ADDR < HALT_BASE |-> LPM_DENY)
		else $error("read of busy concurrent region granted");

	open_store_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		spm_prog && lock_r == `SFL_LOCK_RESET |=> !SPM_REJECT && (FLASH_ERASE_GO || FLASH_WRITE_GO))
		else $error("store refused with both regions open");

	page_latch_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		spm_go |=> FLASH_PAGE == $past(SPM_ADDR))
		else $error("accepted store did not latch its page");
endmodule : sfl_guard

// ---- core/sfl_consts.svh ----
// register offsets, field positions, reset values and timing for the flash lock guard
`ifndef SFL_CONSTS_SVH
`define SFL_CONSTS_SVH
`define SFL_CLK_PERIOD_NS  100
`define SFL_PROG_TIME_NS   4000000
`define SFL_PROG_CYCLES    ((`SFL_PROG_TIME_NS + `SFL_CLK_PERIOD_NS - 1) / `SFL_CLK_PERIOD_NS)
`define SFL_OFS_CTRL       12'h000
`define SFL_OFS_LOCK       12'h004
`define SFL_OFS_STAT       12'h008
`define SFL_CTRL_IVEC_BIT  0
`define SFL_CTRL_BCLR_BIT  1
`define SFL_CTRL_RCLR_BIT  2
`define SFL_LOCK_APP_LSB   0
`define SFL_LOCK_LDR_LSB   2
`define SFL_LOCK_RESET     4'hf
`define SFL_STAT_BUSY_BIT  0
`define SFL_STAT_HALT_BIT  1
`define SFL_STAT_ACT_BIT   2
`define SFL_STAT_REJ_BIT   3
`define SFL_MODE_OPEN      2'h3
`define SFL_MODE_NOWR      2'h2
`define SFL_MODE_FULL      2'h0
`define SFL_MODE_NORD      2'h1
`endif

// ---- core/sfl_pkg.sv ----
// types shared by the flash lock guard modules
package sfl_pkg;
	typedef enum logic [1:0] {SFL_SPM_FILL, SFL_SPM_ERASE, SFL_SPM_WRITE, SFL_SPM_LOCKSET} sfl_spm_kind_t;
	typedef enum logic {SFL_ST_IDLE, SFL_ST_RUN} sfl_seq_state_t;
endpackage : sfl_pkg

// ---- core/sfl_core_if.sv ----
// signals between the guard top, its lock policy and its operation sequencer
`timescale 1ns/1ns
interface sfl_core_if;
	logic [1:0] app_lock;
	logic [1:0] ldr_lock;
	logic       pc_in_ldr;
	logic       ivec_in_ldr;
	logic       spm_tgt_ldr;
	logic       lpm_tgt_ldr;
	logic       spm_write_ok;
	logic       lpm_read_ok;
	logic       irq_suppress;
	logic       start;
	logic       start_halt;
	logic       active;
	logic       halting;
	logic       done;
	modport pol (input app_lock, ldr_lock, pc_in_ldr, ivec_in_ldr, spm_tgt_ldr, lpm_tgt_ldr,
		output spm_write_ok, lpm_read_ok, irq_suppress);
	modport seq (input start, start_halt, output active, halting, done);
	modport top (output app_lock, ldr_lock, pc_in_ldr, ivec_in_ldr, spm_tgt_ldr, lpm_tgt_ldr,
		start, start_halt, input spm_write_ok, lpm_read_ok, irq_suppress, active, halting, done);
endinterface : sfl_core_if

// ---- core/sfl_lock_policy.sv ----
// lock field decode: write, cross-region read and interrupt permissions
`timescale 1ns/1ns
`include "sfl_consts.svh"
module sfl_lock_policy (
	sfl_core_if.pol p
);
	logic app_wr_blk;
	logic app_rd_blk;
	logic ldr_wr_blk;
	logic ldr_rd_blk;

	// general lock modes never enter here, only the two region fields do
	always_comb begin
		case (p.app_lock)
			`SFL_MODE_OPEN: begin app_wr_blk = 1'b0; app_rd_blk = 1'b0; end
			`SFL_MODE_NOWR: begin app_wr_blk = 1'b1; app_rd_blk = 1'b0; end
			`SFL_MODE_FULL: begin app_wr_blk = 1'b1; app_rd_blk = 1'b1; end
			`SFL_MODE_NORD: begin app_wr_blk = 1'b0; app_rd_blk = 1'b1; end
			default:        begin app_wr_blk = 1'b1; app_rd_blk = 1'b1; end
		endcase
		case (p.ldr_lock)
			`SFL_MODE_OPEN: begin ldr_wr_blk = 1'b0; ldr_rd_blk = 1'b0; end
			`SFL_MODE_NOWR: begin ldr_wr_blk = 1'b1; ldr_rd_blk = 1'b0; end
			`SFL_MODE_FULL: begin ldr_wr_blk = 1'b1; ldr_rd_blk = 1'b1; end
			`SFL_MODE_NORD: begin ldr_wr_blk = 1'b0; ldr_rd_blk = 1'b1; end
			default:        begin ldr_wr_blk = 1'b1; ldr_rd_blk = 1'b1; end
		endcase
	end

	assign p.spm_write_ok = p.spm_tgt_ldr ? !ldr_wr_blk : !app_wr_blk;
	// reads inside the running region are always allowed
	assign p.lpm_read_ok  = !((!p.lpm_tgt_ldr && p.pc_in_ldr && app_rd_blk) ||
		(p.lpm_tgt_ldr && !p.pc_in_ldr && ldr_rd_blk));
	assign p.irq_suppress = (!p.pc_in_ldr && app_rd_blk && p.ivec_in_ldr) ||
		(p.pc_in_ldr && ldr_rd_blk && !p.ivec_in_ldr);
endmodule : sfl_lock_policy

// ---- core/sfl_prog_seq.sv ----
// timed page erase / page write sequencer
`timescale 1ns/1ns
module sfl_prog_seq #(
	parameter int CYCLES = 40000
) (
	input  wire logic clk,
	input  wire logic rst,
	sfl_core_if.seq   s
);
	localparam int CW = $clog2(CYCLES + 1);
	sfl_pkg::sfl_seq_state_t state_r;
	logic [CW-1:0]           cnt_r;
	logic                    halt_r;
	logic                    done_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= sfl_pkg::SFL_ST_IDLE;
			cnt_r   <= '0;
			halt_r  <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				sfl_pkg::SFL_ST_IDLE: begin
					if (s.start) begin
						state_r <= sfl_pkg::SFL_ST_RUN;
						cnt_r   <= CW'(CYCLES - 1);
						halt_r  <= s.start_halt;
					end
				end
				sfl_pkg::SFL_ST_RUN: begin
					if (cnt_r == '0) begin
						state_r <= sfl_pkg::SFL_ST_IDLE;
						halt_r  <= 1'b0;
						done_r  <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: state_r <= sfl_pkg::SFL_ST_IDLE;
			endcase
		end
	end

	assign s.active  = (state_r == sfl_pkg::SFL_ST_RUN);
	assign s.halting = halt_r;
	assign s.done    = done_r;

	seq_end_a: assert property (@(posedge clk) disable iff (rst)
		s.active && cnt_r == '0 |=> !s.active && !s.halting && s.done)
		else $error("sequencer did not finish at zero count");
endmodule : sfl_prog_seq

// ---- tb/sfl_cpu_model.sv ----
// processor core model issuing program store, program load and interrupt requests
`timescale 1ns/1ns
module sfl_cpu_model #(
	parameter int AW = 15
) (
	input  wire logic          clk,
	input  wire logic          cpu_stall,
	input  wire logic          lpm_grant,
	input  wire logic          lpm_deny,
	output logic               spm_req,
	output logic      [1:0]    spm_kind,
	output logic      [AW-1:0] spm_addr,
	output logic      [3:0]    spm_lock_data,
	output logic               lpm_req,
	output logic      [AW-1:0] lpm_addr,
	output logic      [AW-1:0] pc_addr,
	output logic               irq_in
);
	int stall_timeouts = 0;
	initial begin
		spm_req = 1'b0;
		spm_kind = 2'h0;
		spm_addr = '0;
		spm_lock_data = 4'hf;
		lpm_req = 1'b0;
		lpm_addr = '0;
		pc_addr = 15'h7a00;
		irq_in = 1'b0;
	end
	// a halted core issues no store until the stall ends or 200 cycles pass; loads are not held back
	task store_to_program_instr(input logic [1:0] k, input logic [AW-1:0] a, input logic [3:0] d);
		int i;
		for (i = 0; i < 200 && cpu_stall !== 1'b0; i++) @(posedge clk);
		if (i == 200) stall_timeouts++;
		@(posedge clk);
		spm_req <= 1'b1;
		spm_kind <= k;
		spm_addr <= a;
		spm_lock_data <= d;
		@(posedge clk);
		spm_req <= 1'b0;
		// released address lines show no stale value
		spm_addr <= ~a;
		spm_lock_data <= ~d;
	endtask : store_to_program_instr
	task lpm(input logic [AW-1:0] a, output logic g, output logic d);
		@(posedge clk);
		lpm_req <= 1'b1;
		lpm_addr <= a;
		@(posedge clk);
		g = lpm_grant;
		d = lpm_deny;
		lpm_req <= 1'b0;
		lpm_addr <= ~a;
	endtask : lpm
	task set_pc(input logic [AW-1:0] a, input logic q);
		@(posedge clk);
		pc_addr <= a;
		irq_in <= q;
	endtask : set_pc
endmodule : sfl_cpu_model

// ---- tb/sfl_guard_tb.sv ----
// self-checking bench for the flash lock guard
`timescale 1ns/1ns
module sfl_guard_tb;
	localparam int PC = 20;
	logic        CORE_CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic        EXT_LOCK_WE = 0, EXT_CHIP_ERASE = 0;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA;
	logic [3:0]  EXT_LOCK_DATA = 0, SPM_LOCK_DATA;
	logic        PREADY, PSLVERR, CPU_STALL, CONC_READ_BLOCK, LPM_GRANT, LPM_DENY, IRQ_OUT;
	logic        FLASH_ERASE_GO, FLASH_WRITE_GO, SPM_REJECT, SPM_REQ, LPM_REQ, IRQ_IN;
	logic [1:0]  SPM_KIND;
	logic [14:0] FLASH_PAGE, SPM_ADDR, LPM_ADDR, PC_ADDR, aa, la, ha, ca;
	logic [1:0]  vals [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
	logic [1:0]  app, ldr;
	logic        g, d;
	int          mismatches = 0, num_checks = 0, n, i;
	logic [17:0] exp_op [$];
	logic [31:0] exp_rd [$];
	sfl_guard #(.PROG_CYCLES(PC)) dut_u (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SPM_REQ(SPM_REQ), .SPM_KIND(SPM_KIND), .SPM_ADDR(SPM_ADDR), .SPM_LOCK_DATA(SPM_LOCK_DATA),
		.LPM_REQ(LPM_REQ), .LPM_ADDR(LPM_ADDR), .PC_ADDR(PC_ADDR), .IRQ_IN(IRQ_IN), .EXT_LOCK_WE(EXT_LOCK_WE),
		.EXT_LOCK_DATA(EXT_LOCK_DATA), .EXT_CHIP_ERASE(EXT_CHIP_ERASE), .CPU_STALL(CPU_STALL),
		.CONC_READ_BLOCK(CONC_READ_BLOCK), .LPM_GRANT(LPM_GRANT), .LPM_DENY(LPM_DENY), .IRQ_OUT(IRQ_OUT),
		.FLASH_ERASE_GO(FLASH_ERASE_GO), .FLASH_WRITE_GO(FLASH_WRITE_GO), .FLASH_PAGE(FLASH_PAGE),
		.SPM_REJECT(SPM_REJECT));
	sfl_cpu_model cpu_u (.clk(CORE_CLK), .cpu_stall(CPU_STALL), .lpm_grant(LPM_GRANT), .lpm_deny(LPM_DENY),
		.spm_req(SPM_REQ), .spm_kind(SPM_KIND), .spm_addr(SPM_ADDR), .spm_lock_data(SPM_LOCK_DATA),
		.lpm_req(LPM_REQ), .lpm_addr(LPM_ADDR), .pc_addr(PC_ADDR), .irq_in(IRQ_IN));
	initial begin
		forever #50 CORE_CLK = ~CORE_CLK;
	end
	task summarize;
		if (exp_op.size() + exp_rd.size() != 0) mismatches++;
		mismatches += cpu_u.stall_timeouts;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] e, input string m);
		num_checks++;
		if (got !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] e);
		int k;
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		if (!w) exp_rd.push_back(e);
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge CORE_CLK);
			if (PREADY === 1'b1) break;
		end
		if (k == 20) begin
			chk(1, 0, "bus timeout");
			summarize();
		end
		chk(PSLVERR, a > 12'h008, "slave error");
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task try_op(input logic [1:0] k, input logic [14:0] a, input logic ok, input logic h);
		exp_op.push_back(ok ? {1'b0, k == 2'h2, k == 2'h1, a} : {3'b100, a});
		cpu_u.store_to_program_instr(k, a, 4'hf);
		@(negedge CORE_CLK);
		chk(CPU_STALL, ok & h, "stall on store");
		repeat (PC + 3) @(posedge CORE_CLK);
		apb(1'b0, 12'h008, 32'h0, {28'h0, ~ok, 2'b00, ok & ~h});
		apb(1'b1, 12'h000, 32'h6, 32'h0);
	endtask : try_op
	// result watcher: store outcomes and read data against the oldest note
	always @(negedge CORE_CLK) begin : mon
		logic [17:0] e;
		if (FLASH_ERASE_GO === 1'b1 || FLASH_WRITE_GO === 1'b1 || SPM_REJECT === 1'b1) begin
			if (exp_op.size() == 0) chk(1, 0, "unexpected store outcome");
			else begin
				e = exp_op.pop_front();
				if (e[17]) chk({SPM_REJECT, FLASH_WRITE_GO, FLASH_ERASE_GO}, e[17:15], "reject");
				else chk({SPM_REJECT, FLASH_WRITE_GO, FLASH_ERASE_GO, FLASH_PAGE}, e, "store go");
			end
		end
		if (PSEL === 1'b1 && PENABLE === 1'b1 && PWRITE === 1'b0 && PREADY === 1'b1) begin
			if (exp_rd.size() == 0) chk(1, 0, "unexpected read");
			else chk(PRDATA, exp_rd.pop_front(), "read data");
		end
	end
	initial begin
		repeat (100000) @(posedge CORE_CLK);
		chk(1, 0, "watchdog");
		summarize();
	end
	initial begin
		void'($urandom(82907));
		repeat (6) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		apb(1'b0, 12'h004, 32'h0, 32'hf);
		apb(1'b1, 12'h004, 32'h0, 32'h0);
		apb(1'b0, 12'h004, 32'h0, 32'hf);
		apb(1'b0, 12'h00c, 32'h0, 32'h0);
		ha = 15'(15'h7000 + $urandom_range(0, 15'h7ff));
		exp_op.push_back({3'b001, ha});
		cpu_u.store_to_program_instr(2'h1, ha, 4'hf);
		n = 0;
		repeat (40) @(negedge CORE_CLK) n += (CPU_STALL === 1'b1);
		chk(n, PC, "halting stall length");
		apb(1'b1, 12'h000, 32'h6, 32'h0);
		ca = 15'($urandom_range(0, 15'h6fff));
		exp_op.push_back({3'b010, ca});
		cpu_u.store_to_program_instr(2'h2, ca, 4'hf);
		@(negedge CORE_CLK);
		chk({CPU_STALL, CONC_READ_BLOCK}, 2'b01, "concurrent op");
		cpu_u.lpm(ca, g, d);
		chk({g, d}, 2'b01, "read of busy region");
		cpu_u.lpm(15'h7200, g, d);
		chk({g, d}, 2'b10, "read of halting region");
		repeat (PC + 3) @(posedge CORE_CLK);
		apb(1'b0, 12'h008, 32'h0, 32'h1);
		apb(1'b1, 12'h000, 32'h2, 32'h0);
		apb(1'b0, 12'h008, 32'h0, 32'h0);
		chk(CONC_READ_BLOCK, 0, "busy cleared");
		for (i = 0; i < 4; i++) begin
			app = vals[i];
			ldr = vals[(i + 1) % 4];
			aa = 15'($urandom_range(0, 15'h6fff));
			la = 15'(15'h7800 + $urandom_range(0, 15'h7ff));
			EXT_CHIP_ERASE <= 1'b1;
			repeat (5) @(posedge CORE_CLK);
			EXT_CHIP_ERASE <= 1'b0;
			EXT_LOCK_DATA <= {ldr, app};
			repeat (4) @(posedge CORE_CLK);
			EXT_LOCK_WE <= 1'b1;
			repeat (6) @(posedge CORE_CLK);
			EXT_LOCK_WE <= 1'b0;
			repeat (5) @(posedge CORE_CLK);
			cpu_u.store_to_program_instr(2'h3, 15'h0, 4'hf);
			apb(1'b0, 12'h004, 32'h0, {28'h0, ldr, app});
			try_op(2'h1, aa, app[0], 1'b0);
			try_op(2'h2, la, ldr[0], 1'b1);
			cpu_u.lpm(aa, g, d);
			chk({g, d}, {app[1], ~app[1]}, "loader reads app");
			apb(1'b1, 12'h000, 32'h1, 32'h0);
			cpu_u.set_pc(15'h0300, 1'b1);
			repeat (3) @(negedge CORE_CLK);
			chk(IRQ_OUT, app[1], "irq in app");
			cpu_u.lpm(la, g, d);
			chk({g, d}, {ldr[1], ~ldr[1]}, "app reads loader");
			cpu_u.store_to_program_instr(2'h1, aa, 4'hf);
			repeat (3) @(posedge CORE_CLK);
			apb(1'b1, 12'h000, 32'h0, 32'h0);
			cpu_u.set_pc(15'h7a00, 1'b1);
			repeat (3) @(negedge CORE_CLK);
			chk(IRQ_OUT, ldr[1], "irq in loader");
			cpu_u.set_pc(15'h7a00, 1'b0);
		end
		// a lock store can only program bits, never release them
		cpu_u.store_to_program_instr(2'h3, 15'h0, 4'hf);
		apb(1'b0, 12'h004, 32'h0, {28'h0, ldr, app});
		cpu_u.store_to_program_instr(2'h3, 15'h0, 4'h7);
		apb(1'b0, 12'h004, 32'h0, {28'h0, ldr & 2'b01, app});
		summarize();
	end
endmodule : sfl_guard_tb
